// ==== src/pps_power_seq.sv ====
// Purpose: power-up reset, dac format setup and orderly power-down
// Assumes: supply indicator and on/off switch are asynchronous pins
// Notes: the dac is reached through the local two-wire bus master below
`timescale 1ns/1ps

// Notes on behaviour
// - Sequencer drives the controller reset and holds it until supply is stable.
// - Controller and system stay in reset while the supply is not yet stable.
// - Supply-ok indicator is sampled to judge the supply above minimum and stable.
// - After power-up, write the dac serial-audio format to match the decoder.
// - Switch off or supply low disables all player operation.
// - Power-down first puts the dac in low-power mode over the bus.
// - Battery power to the converter is removed only after that write completes, except on switch off while still in hold, where no write is made.
// - Power-down starts on low supply or when the user switches off.
// - The bus master drives both the clock and data lines.
// - Each bus transfer starts through a simple request to the bus master.
// - The bus master is the only master; no arbitration or slave logic.
// - Dac low-power mode is a one written to its power-down bit.
module pps_power_seq #(
  parameter int STABLE_CYC = pps_pkg::STABLE_CYC,
  parameter int QTR_CYC = pps_pkg::I2C_QTR_CYC,
  parameter logic [6:0] DEV_ADDR = pps_pkg::DAC_DEV_ADDR,
  parameter logic [7:0] FORMAT_REG = pps_pkg::DAC_FORMAT_REG,
  parameter logic [7:0] GLOBAL_CFG_REG = pps_pkg::DAC_GLOBAL_CFG_REG,
  parameter int PWR_DOWN_POS = pps_pkg::DAC_PWR_DOWN_POS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // board pins
  input wire logic onSwitch,
  input wire logic supplyOkIndicator,
  // configuration from the main control logic
  input wire logic [7:0] dacFormat,
  input wire logic [7:0] globalCfgBase,
  // controls and status towards the system
  output logic ctlRst_n,
  output logic playEnable,
  output logic dcdcEnable,
  output logic cfgDone,
  output logic cfgNack,
  output logic downNack,
  // two-wire bus pins
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe_n,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n
);
  import pps_pkg::*;

  localparam int CNT_W = $clog2(STABLE_CYC + 1);
  // power-down value keeps the other global bits as the system set them
  localparam logic [7:0] PWR_DOWN_MASK = 8'h01 << PWR_DOWN_POS;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] onSync_r;
  logic [1:0] supSync_r;
  logic onOk;
  logic supOk;
  logic offCond;

  // two flops each; only the second stage feeds logic
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      // reads on at reset, so no false off cause before the pin is seen
      onSync_r <= 2'h3;
      supSync_r <= 2'h0;
    end else begin
      onSync_r <= {onSync_r[0], onSwitch};
      supSync_r <= {supSync_r[0], supplyOkIndicator};
    end
  end

  assign onOk = onSync_r[1];
  assign supOk = supSync_r[1];
  // either cause starts the same power-down
  assign offCond = !onOk || !supOk;

  // ----------------------------------------------------------------
  // bus master request
  // ----------------------------------------------------------------
  logic i2cReq;
  logic [7:0] i2cReg;
  logic [7:0] i2cData;
  logic i2cBusy;
  logic i2cDone;
  logic i2cNack;
  pps_seq_state_t state_r, state_nxt;

  // one request cycle per transfer; master is idle whenever we ask
  assign i2cReq = (state_r == SEQ_CFG_REQ) || (state_r == SEQ_DOWN_REQ);
  assign i2cReg = (state_r == SEQ_DOWN_REQ) ? GLOBAL_CFG_REG : FORMAT_REG;
  // setting the power-down bit puts the dac in low power
  assign i2cData = (state_r == SEQ_DOWN_REQ) ? (globalCfgBase | PWR_DOWN_MASK)
                                             : dacFormat;

  pps_i2c_master #(
    .QTR_CYC(QTR_CYC)
  ) u_i2c (
    .mclk(mclk),
    .arst_n(arst_n),
    .req(i2cReq),
    .devAddr(DEV_ADDR),
    .regAddr(i2cReg),
    .wrData(i2cData),
    .busy(i2cBusy),
    .done(i2cDone),
    .nack(i2cNack),
    .sclIn(sclIn),
    .sclOut(sclOut),
    .sclOe_n(sclOe_n),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] stableCnt_r, stableCnt_nxt;
  logic ctlRst_n_r, ctlRst_n_nxt;
  logic playEnable_r, playEnable_nxt;
  logic dcdcEnable_r, dcdcEnable_nxt;
  logic cfgDone_r, cfgDone_nxt;
  logic cfgNack_r, cfgNack_nxt;
  logic downNack_r, downNack_nxt;

  // next-state logic for the whole power sequence
  always_comb begin
    state_nxt = state_r;
    stableCnt_nxt = stableCnt_r;
    ctlRst_n_nxt = ctlRst_n_r;
    playEnable_nxt = playEnable_r;
    dcdcEnable_nxt = dcdcEnable_r;
    cfgDone_nxt = cfgDone_r;
    cfgNack_nxt = cfgNack_r;
    downNack_nxt = downNack_r;
    case (state_r)
      SEQ_HOLD: begin
        ctlRst_n_nxt = 1'b0;
        if (!onOk) begin
          // dac never set up yet, nothing to park on the bus
          state_nxt = SEQ_OFF;
          dcdcEnable_nxt = 1'b0;
        end else if (!supOk) begin
          stableCnt_nxt = '0;
        end else if (stableCnt_r == CNT_W'(STABLE_CYC - 1)) begin
          state_nxt = SEQ_CFG_REQ;
          ctlRst_n_nxt = 1'b1;
        end else begin
          stableCnt_nxt = stableCnt_r + 1'b1;
        end
      end
      SEQ_CFG_REQ: begin
        state_nxt = SEQ_CFG_WAIT;
      end
      SEQ_CFG_WAIT: begin
        if (i2cDone) begin
          cfgDone_nxt = 1'b1;
          cfgNack_nxt = i2cNack;
          state_nxt = offCond ? SEQ_DOWN_REQ : SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (offCond) begin
          state_nxt = SEQ_DOWN_REQ;
        end
      end
      SEQ_DOWN_REQ: begin
        state_nxt = SEQ_DOWN_WAIT;
      end
      SEQ_DOWN_WAIT: begin
        // battery stays on until the low-power write has finished, acked or not
        if (i2cDone) begin
          downNack_nxt = i2cNack;
          dcdcEnable_nxt = 1'b0;
          state_nxt = SEQ_OFF;
        end
      end
      SEQ_OFF: begin
        ctlRst_n_nxt = 1'b0;
        // back to hold as soon as the switch reads on; supply is not checked here
        if (onOk) begin
          state_nxt = SEQ_HOLD;
          dcdcEnable_nxt = 1'b1;
          stableCnt_nxt = '0;
          cfgDone_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = SEQ_HOLD;
      end
    endcase
    // play only after setup is reported, dropped on any off cause
    playEnable_nxt = (state_nxt == SEQ_RUN) && cfgDone_nxt && !offCond;
  end

  // state registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= SEQ_HOLD;
      stableCnt_r <= '0;
      ctlRst_n_r <= CTL_RST_N_RST;
      playEnable_r <= PLAY_EN_RST;
      dcdcEnable_r <= DCDC_EN_RST;
      cfgDone_r <= 1'b0;
      cfgNack_r <= 1'b0;
      downNack_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      stableCnt_r <= stableCnt_nxt;
      ctlRst_n_r <= ctlRst_n_nxt;
      playEnable_r <= playEnable_nxt;
      dcdcEnable_r <= dcdcEnable_nxt;
      cfgDone_r <= cfgDone_nxt;
      cfgNack_r <= cfgNack_nxt;
      downNack_r <= downNack_nxt;
    end
  end

  assign ctlRst_n = ctlRst_n_r;
  assign playEnable = playEnable_r;
  assign dcdcEnable = dcdcEnable_r;
  assign cfgDone = cfgDone_r;
  assign cfgNack = cfgNack_r;
  assign downNack = downNack_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // run of consecutive good supply samples, for the release check only
  logic [CNT_W-1:0] okRun_r;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      okRun_r <= '0;
    end else if (!supOk) begin
      okRun_r <= '0;
    end else if (okRun_r != CNT_W'(STABLE_CYC)) begin
      okRun_r <= okRun_r + 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_release_good: assert property (
    $rose(ctlRst_n_r) |-> $past(supOk) && $past(state_r) == SEQ_HOLD)
    else $error("reset released outside the hold state or with bad supply");
  a_hold_in_reset: assert property (
    (state_r == SEQ_HOLD && !supOk) |=> !ctlRst_n_r)
    else $error("reset released while supply not good");
  a_stable_run: assert property (
    $rose(ctlRst_n_r) |-> okRun_r >= CNT_W'(STABLE_CYC - 1))
    else $error("reset released before supply was good long enough");
  a_cfg_write: assert property (
    $rose(ctlRst_n_r) |-> i2cReq && i2cReg == FORMAT_REG && i2cData == dacFormat
      ##1 i2cBusy)
    else $error("format write not requested at reset release");
  a_play_off: assert property (
    offCond |=> !playEnable_r)
    else $error("play left enabled with switch off or low supply");
  a_down_start: assert property (
    (state_r == SEQ_RUN && offCond) |=> state_r == SEQ_DOWN_REQ ##1 i2cBusy)
    else $error("power-down not started on off cause");
  a_down_write: assert property (
    (state_r == SEQ_DOWN_REQ) |-> i2cReq && i2cReg == GLOBAL_CFG_REG)
    else $error("power-down write aimed at wrong dac register");
  a_down_bit: assert property (
    (state_r == SEQ_DOWN_REQ) |-> i2cData[PWR_DOWN_POS])
    else $error("power-down bit not set in low-power write");
  a_power_after: assert property (
    (state_r == SEQ_RUN && dcdcEnable_r) |-> ##1 dcdcEnable_r ##1 dcdcEnable_r)
    else $error("converter power dropped without a dac write");
  a_power_cause: assert property (
    ($fell(dcdcEnable_r) && $past(state_r) != SEQ_HOLD) |->
      $past(i2cDone) && $past(state_r) == SEQ_DOWN_WAIT)
    else $error("converter power removed before the dac write finished");
  a_cfg_report: assert property (
    $rose(playEnable_r) |-> cfgDone_r && $past(cfgDone_r || i2cDone))
    else $error("play enabled before setup completion was reported");
  a_single_req: assert property (
    i2cReq |-> !i2cBusy)
    else $error("request issued while the bus master was busy");

endmodule : pps_power_seq

// ==== shared/pps_pkg.sv ====
// Purpose: constants and types shared by the player power sequencer files
// Assumes: mclk at 200 MHz; one clock domain
// Notes: times are kept in their own unit and turned into cycle counts here
package pps_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  // quarter of a 100 kHz two-wire bit period
  localparam int I2C_QTR_NS = 2500;
  // least time, so round up
  localparam int I2C_QTR_CYC = (I2C_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // supply must read good this long before reset is released
  localparam int STABLE_US = 1000;
  localparam int STABLE_CYC = (STABLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // two-wire bus frame layout
  // ----------------------------------------------------------------
  localparam int BYTE_BITS = 8;
  localparam int FRAME_BYTES = 3;

  // ----------------------------------------------------------------
  // dac addressing defaults (plain values, override per board)
  // ----------------------------------------------------------------
  localparam logic [6:0] DAC_DEV_ADDR = 7'h4d;
  localparam logic [7:0] DAC_FORMAT_REG = 8'h02;
  localparam logic [7:0] DAC_GLOBAL_CFG_REG = 8'h03;
  localparam int DAC_PWR_DOWN_POS = 0;

  // ----------------------------------------------------------------
  // reset values of the sequencer outputs
  // ----------------------------------------------------------------
  localparam logic CTL_RST_N_RST = 1'b0;
  localparam logic DCDC_EN_RST = 1'b1;
  localparam logic PLAY_EN_RST = 1'b0;

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_HOLD, SEQ_CFG_REQ, SEQ_CFG_WAIT, SEQ_RUN,
    SEQ_DOWN_REQ, SEQ_DOWN_WAIT, SEQ_OFF
  } pps_seq_state_t;

  typedef enum logic [1:0] {
    I2C_IDLE, I2C_START, I2C_DATA, I2C_STOP
  } pps_i2c_state_t;

endpackage : pps_pkg

// ==== src/pps_i2c_master.sv ====
// Purpose: write-only two-wire bus master for the dac (device, register, data)
// Assumes: sole master on a local bus; open-drain scl and sda
// Notes: scl is released high and may be held low by a slave (stretching)
`timescale 1ns/1ps
module pps_i2c_master #(
  parameter int QTR_CYC = pps_pkg::I2C_QTR_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // request side
  input wire logic req,
  input wire logic [6:0] devAddr,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] wrData,
  output logic busy,
  output logic done,
  output logic nack,
  // bus pins
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe_n,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n
);
  import pps_pkg::*;

  localparam int DIV_W = $clog2(QTR_CYC + 1);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sclSync_r;
  logic [1:0] sdaSync_r;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sclSync_r <= 2'h3;
      sdaSync_r <= 2'h3;
    end else begin
      sclSync_r <= {sclSync_r[0], sclIn};
      sdaSync_r <= {sdaSync_r[0], sdaIn};
    end
  end

  // ----------------------------------------------------------------
  // bit engine
  // ----------------------------------------------------------------
  pps_i2c_state_t state_r, state_nxt;
  logic [DIV_W-1:0] divCnt_r, divCnt_nxt;
  logic [1:0] qIdx_r, qIdx_nxt;
  logic [3:0] bitCnt_r, bitCnt_nxt;
  logic [1:0] byteCnt_r, byteCnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] reg_r, reg_nxt;
  logic [7:0] dat_r, dat_nxt;
  logic sclOe_n_r, sclOe_n_nxt;
  logic sdaOe_n_r, sdaOe_n_nxt;
  logic done_r, done_nxt;
  logic nack_r, nack_nxt;
  logic stall;
  logic tick;
  logic [7:0] nextByte;

  // a released scl still read low means a slave stretches the clock
  assign stall = sclOe_n_r && !sclSync_r[1];
  assign tick = (divCnt_r == DIV_W'(QTR_CYC - 1)) && !stall;
  assign nextByte = (byteCnt_r == 2'h0) ? reg_r : dat_r;

  always_comb begin
    state_nxt = state_r;
    divCnt_nxt = divCnt_r;
    qIdx_nxt = qIdx_r;
    bitCnt_nxt = bitCnt_r;
    byteCnt_nxt = byteCnt_r;
    shift_nxt = shift_r;
    reg_nxt = reg_r;
    dat_nxt = dat_r;
    sclOe_n_nxt = sclOe_n_r;
    sdaOe_n_nxt = sdaOe_n_r;
    done_nxt = 1'b0;
    nack_nxt = nack_r;
    if (state_r != I2C_IDLE && !stall) begin
      divCnt_nxt = tick ? '0 : divCnt_r + 1'b1;
    end
    if (tick) begin
      qIdx_nxt = qIdx_r + 2'h1;
    end
    case (state_r)
      I2C_IDLE: begin
        if (req) begin
          state_nxt = I2C_START;
          divCnt_nxt = '0;
          qIdx_nxt = 2'h0;
          shift_nxt = {devAddr, 1'b0};
          reg_nxt = regAddr;
          dat_nxt = wrData;
          byteCnt_nxt = 2'h0;
          bitCnt_nxt = 4'h0;
          nack_nxt = 1'b0;
        end
      end
      I2C_START: begin
        if (tick && qIdx_r == 2'h0) begin
          sdaOe_n_nxt = 1'b0; // start: sda falls while scl high
        end
        if (tick && qIdx_r == 2'h2) begin
          sclOe_n_nxt = 1'b0;
        end
        if (tick && qIdx_r == 2'h3) begin
          state_nxt = I2C_DATA;
          sdaOe_n_nxt = shift_r[7];
        end
      end
      I2C_DATA: begin
        if (tick && qIdx_r == 2'h1) begin
          sclOe_n_nxt = 1'b1;
        end
        if (tick && qIdx_r == 2'h2 && bitCnt_r == 4'h8) begin
          nack_nxt = sdaSync_r[1];
        end
        if (tick && qIdx_r == 2'h3) begin
          sclOe_n_nxt = 1'b0;
          if (bitCnt_r == 4'h8) begin
            if (nack_r || byteCnt_r == 2'(FRAME_BYTES - 1)) begin
              state_nxt = I2C_STOP;
              sdaOe_n_nxt = 1'b0;
            end else begin
              shift_nxt = nextByte;
              byteCnt_nxt = byteCnt_r + 2'h1;
              bitCnt_nxt = 4'h0;
              sdaOe_n_nxt = nextByte[7];
            end
          end else begin
            shift_nxt = {shift_r[6:0], 1'b0};
            bitCnt_nxt = bitCnt_r + 4'h1;
            // release sda for the acknowledge slot
            sdaOe_n_nxt = (bitCnt_r == 4'h7) ? 1'b1 : shift_r[6];
          end
        end
      end
      I2C_STOP: begin
        if (tick && qIdx_r == 2'h1) begin
          sclOe_n_nxt = 1'b1;
        end
        if (tick && qIdx_r == 2'h2) begin
          sdaOe_n_nxt = 1'b1; // stop: sda rises while scl high
        end
        if (tick && qIdx_r == 2'h3) begin
          state_nxt = I2C_IDLE;
          done_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = I2C_IDLE;
      end
    endcase
  end

  // no arbitration or slave logic: this is the only master on the bus
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= I2C_IDLE;
      divCnt_r <= '0;
      qIdx_r <= 2'h0;
      bitCnt_r <= 4'h0;
      byteCnt_r <= 2'h0;
      shift_r <= 8'h00;
      reg_r <= 8'h00;
      dat_r <= 8'h00;
      sclOe_n_r <= 1'b1;
      sdaOe_n_r <= 1'b1;
      done_r <= 1'b0;
      nack_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      divCnt_r <= divCnt_nxt;
      qIdx_r <= qIdx_nxt;
      bitCnt_r <= bitCnt_nxt;
      byteCnt_r <= byteCnt_nxt;
      shift_r <= shift_nxt;
      reg_r <= reg_nxt;
      dat_r <= dat_nxt;
      sclOe_n_r <= sclOe_n_nxt;
      sdaOe_n_r <= sdaOe_n_nxt;
      done_r <= done_nxt;
      nack_r <= nack_nxt;
    end
  end

  // open drain: the driven level is always low
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe_n = sclOe_n_r;
  assign sdaOe_n = sdaOe_n_r;
  assign busy = (state_r != I2C_IDLE);
  assign done = done_r;
  assign nack = nack_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_req_taken: assert property (@(posedge mclk) disable iff (!arst_n)
    (req && !busy) |=> busy)
    else $error("request not taken by idle bus master");
  a_sda_stable_high: assert property (@(posedge mclk) disable iff (!arst_n)
    (state_r == I2C_DATA && sclOe_n_r && $past(sclOe_n_r)) |-> $stable(sdaOe_n_r))
    else $error("sda changed while scl high inside a byte");

endmodule : pps_i2c_master

// ==== tb/pps_dac_model.sv ====
// Purpose: behavioural dac on the local two-wire bus, write side only
// Assumes: bench resolves the wires with pull-ups; this model never drives high
// Notes: acks each byte, or refuses all with nackMode; stretch slows scl
`timescale 1ns/1ps
module pps_dac_model (
  // bus wires
  input wire logic scl,
  input wire logic sda,
  output logic sclHold_n,
  output logic sdaOe_n,
  // test controls
  input wire logic nackMode,
  input wire logic stretch
);
  logic [7:0] shiftReg;
  logic [7:0] rxBytes [3];
  int bitCnt = 0;
  int byteCnt = 0;
  int frames = 0;
  initial begin
    sdaOe_n = 1'b1;
    sclHold_n = 1'b1;
  end
  // --------------------------------------------------------------
  // framing
  // --------------------------------------------------------------
  // start resets the byte counter, stop closes a frame
  // look 1 ns late: sda may move in the same step in which scl falls
  always @(negedge sda) begin
    #1;
    if (scl === 1'b1) begin
      bitCnt = 0;
      byteCnt = 0;
    end
  end
  always @(posedge sda) begin
    #1;
    if (scl === 1'b1 && byteCnt > 0) frames++;
  end
  // data sampled msb first while scl is high
  always @(posedge scl) if (bitCnt < 8) begin
    shiftReg = {shiftReg[6:0], sda};
    bitCnt++;
  end
  // ack slot driven and released on falling scl, never while scl high
  always @(negedge scl) begin
    if (bitCnt == 8) begin
      if (byteCnt < 3) rxBytes[byteCnt] = shiftReg;
      byteCnt++;
      bitCnt = 9;
      sdaOe_n = nackMode;
    end else if (bitCnt == 9) begin
      bitCnt = 0;
      sdaOe_n = 1'b1;
    end
    // slow answer: hold the clock low past the master's quarter
    if (stretch) begin
      sclHold_n = 1'b0;
      #50 sclHold_n = 1'b1;
    end
  end
endmodule : pps_dac_model

// ==== tb/test_player_power_sequencer.sv ====
// Purpose: self-checking bench for the power sequencer
// Assumes: short stable and quarter counts; dac model on the bus
// Notes: wires low when any party enables, else pulled high
`timescale 1ns/1ps
module test_player_power_sequencer;
  import pps_pkg::*;
  localparam int STAB = 20;
  localparam logic [7:0] FMT = 8'h5a;
  localparam logic [7:0] BASE = 8'h84;
  logic mclk, arst_n, onSwitch, supplyOkIndicator, nackMode, stretch;
  logic [7:0] dacFormat, globalCfgBase;
  logic ctlRst_n, playEnable, dcdcEnable, cfgDone, cfgNack, downNack;
  logic sclOut, sclOe_n, sdaOut, sdaOe_n, dacSdaOe_n, sclHold_n;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  wire logic scl = sclOe_n & sclHold_n;
  wire logic sda = sdaOe_n & dacSdaOe_n;

  pps_power_seq #(.STABLE_CYC(STAB), .QTR_CYC(4)) pps_power_seq_inst (
    .mclk(mclk), .arst_n(arst_n), .onSwitch(onSwitch),
    .supplyOkIndicator(supplyOkIndicator), .dacFormat(dacFormat),
    .globalCfgBase(globalCfgBase), .ctlRst_n(ctlRst_n), .playEnable(playEnable),
    .dcdcEnable(dcdcEnable), .cfgDone(cfgDone), .cfgNack(cfgNack),
    .downNack(downNack), .sclIn(scl), .sclOut(sclOut), .sclOe_n(sclOe_n),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n));
  pps_dac_model pps_dac_model_inst (
    .scl(scl), .sda(sda), .sclHold_n(sclHold_n), .sdaOe_n(dacSdaOe_n),
    .nackMode(nackMode), .stretch(stretch));

  // --------------------------------------------------------------
  // clock, timeout and helpers
  // --------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // four frames, the first two stretched, fit well below this ceiling
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("ERROR at %0t: cycles %0h reached limit %0h", $time, cycles, 20000);
      results();
    end
  end
  task results;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  function automatic logic sel(input int w);
    case (w)
      0: return ctlRst_n;
      1: return cfgDone;
      default: return ~dcdcEnable;
    endcase
  endfunction : sel
  // bounded wait, sampled on the falling edge where outputs are settled
  task automatic waitFor(input int w, output int cnt);
    cnt = 0;
    while (sel(w) !== 1'b1 && cnt < 4000) begin
      @(negedge mclk);
      cnt++;
    end
    // a wait that runs out is a mismatch of its own
    if (cnt >= 4000) begin
      error_cnt++;
      $display("ERROR at %0t: wait %0h gave up after %0h cycles", $time, w, cnt);
    end
  endtask : waitFor

  // --------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    onSwitch = 1'b1;
    supplyOkIndicator = 1'b0;
    nackMode = 1'b0;
    stretch = 1'b1;
    dacFormat = FMT;
    globalCfgBase = BASE;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    @(negedge mclk);
    chk({ctlRst_n, playEnable, dcdcEnable, cfgDone, sclOe_n, sdaOe_n, sclOut, sdaOut},
        16'h002c);
    // a short good spell must not release reset
    @(posedge mclk) supplyOkIndicator <= 1'b1;
    repeat (STAB - 4) @(posedge mclk);
    supplyOkIndicator <= 1'b0;
    repeat (8) @(negedge mclk);
    chk(ctlRst_n, 16'h0000);
    @(posedge mclk) supplyOkIndicator <= 1'b1;
    waitFor(0, n);
    chk(n >= STAB && n <= STAB + 4, 16'h0001);
    chk(playEnable, 16'h0000);
    waitFor(1, n);
    chk({pps_dac_model_inst.rxBytes[0], pps_dac_model_inst.rxBytes[1]},
        {DAC_DEV_ADDR, 1'b0, DAC_FORMAT_REG});
    chk(pps_dac_model_inst.rxBytes[2], FMT);
    chk(16'(pps_dac_model_inst.frames), 16'h0001);
    chk({cfgNack, playEnable}, 16'h0001);
    // power-down by the switch
    @(posedge mclk) onSwitch <= 1'b0;
    repeat (5) @(negedge mclk);
    chk({playEnable, dcdcEnable}, 16'h0001);
    waitFor(2, n);
    chk(16'(pps_dac_model_inst.frames), 16'h0002);
    chk({pps_dac_model_inst.rxBytes[1], pps_dac_model_inst.rxBytes[2]},
        {DAC_GLOBAL_CFG_REG, BASE | (8'h01 << DAC_PWR_DOWN_POS)});
    // controller reset follows the converter by one cycle
    @(negedge mclk);
    chk({ctlRst_n, downNack}, 16'h0000);
    // second power-up with a refusing dac, then supply loss
    nackMode = 1'b1;
    stretch = 1'b0;
    @(posedge mclk) onSwitch <= 1'b1;
    // the old done flag stands until the sequencer is back in hold
    repeat (6) @(negedge mclk);
    chk({dcdcEnable, cfgDone}, 16'h0002);
    waitFor(1, n);
    chk({cfgDone, cfgNack}, 16'h0003);
    @(posedge mclk) supplyOkIndicator <= 1'b0;
    waitFor(2, n);
    chk({downNack, dcdcEnable, playEnable}, 16'h0004);
    chk(16'(pps_dac_model_inst.frames), 16'h0004);
    // switch off while still held in reset: no bus write
    @(posedge mclk) onSwitch <= 1'b0;
    repeat (6) @(posedge mclk);
    onSwitch <= 1'b1;
    repeat (6) @(negedge mclk);
    chk({dcdcEnable, ctlRst_n}, 16'h0002);
    @(posedge mclk) onSwitch <= 1'b0;
    repeat (6) @(negedge mclk);
    chk({dcdcEnable, 8'(pps_dac_model_inst.frames)}, 16'h0004);
    results();
  end
endmodule : test_player_power_sequencer
